// File: logic/ovsr_regs.vh
// Register offsets, reset values and scaling constants of the output voltage setpoint bank.
`ifndef OVSR_REGS_VH
`define OVSR_REGS_VH
`define OVSR_ADDR_TARGET     8'h21
`define OVSR_ADDR_TRIM       8'h22
`define OVSR_ADDR_CAL_OFFSET 8'h23
`define OVSR_ADDR_CEILING    8'h24
`define OVSR_ADDR_MARGIN_HI  8'h25
`define OVSR_RESET_ZERO      16'h0000
`define OVSR_PAGE_PH2        8'h00
`define OVSR_PAGE_PH1        8'h01
`define OVSR_PAGE_BOTH       8'hff
`define OVSR_OP_ON           2'h2
`define OVSR_MARGIN_HIGH     2'h2
`define OVSR_CEIL_NUM        17'h00073
`define OVSR_MHI_NUM         17'h00069
`define OVSR_PCT_DEN         17'h00064
`define OVSR_CEIL_ABS_MAX    16'hb000
`define OVSR_TRIM_POS_MAX    16'h04cd
`define OVSR_TRIM_NEG_MAX    16'hfb33
`define OVSR_LOAD_IDLE       2'h0
`define OVSR_LOAD_STEP       2'h1
`define OVSR_LOAD_AT         2'h2
`define OVSR_LOAD_DONE       2'h3
`endif

// File: logic/ovsr_phase.v
// One page of setpoint registers with the commanded-voltage computation for that phase.
`include "ovsr_regs.vh"
module ovsr_phase #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire         load_defaults,
    input  wire [W-1:0] strap_code,
    input  wire         wr_en,
    input  wire [7:0]   wr_addr,
    input  wire [W-1:0] wr_data,
    input  wire [7:0]   rd_addr,
    input  wire [7:0]   operation,
    output reg  [W-1:0] rd_data,
    output reg          rd_hit,
    output reg  [W-1:0] vout_cmd
);
    reg  [W-1:0] target;      // Nominal target code.
    reg  [W-1:0] trim;        // Factory trim, signed.
    reg  [W-1:0] cal_offset;  // User calibration offset, signed.
    reg  [W-1:0] ceiling;     // Absolute upper bound.
    reg  [W-1:0] margin_hi;   // Margin-high target.
    reg  [W-1:0] strap_limit; // 115 percent of the strap, latched at load.
    wire [W:0]   ceil_calc;   // Strap scaled to 115 percent.
    wire [W:0]   mhi_calc;    // Strap scaled to 105 percent.
    reg  [W+2:0] sum;         // Signed sum of setpoint, trim and offset.
    reg  [W-1:0] nominal;     // Target after the limit check.
    reg  [W-1:0] base;        // Selected nominal or margin setpoint.
    reg  [W-1:0] next_vout;   // Clamped command.

    // Percent scaling of the strap code; results saturate so a large strap cannot wrap.
    function [W:0] ovsr_scale;
        input [W-1:0] code;
        input [16:0]  num;
        reg   [33:0]  p;
        begin
            p = ({{17{1'b0}}, code} * {{17{1'b0}}, num}) / {{17{1'b0}}, `OVSR_PCT_DEN};
            ovsr_scale = (p[33:W] != 0) ? {1'b0, {W{1'b1}}} : {1'b0, p[W-1:0]};
        end
    endfunction

    // Trim is held within its plus or minus 150 mV window.
    function [W-1:0] ovsr_trim_lim;
        input [W-1:0] v;
        begin
            if (!v[W-1] && v > `OVSR_TRIM_POS_MAX)
                ovsr_trim_lim = `OVSR_TRIM_POS_MAX;
            else if (v[W-1] && v < `OVSR_TRIM_NEG_MAX)
                ovsr_trim_lim = `OVSR_TRIM_NEG_MAX;
            else
                ovsr_trim_lim = v;
        end
    endfunction

    assign ceil_calc = ovsr_scale(strap_code, `OVSR_CEIL_NUM);
    assign mhi_calc  = ovsr_scale(strap_code, `OVSR_MHI_NUM);

    // Register writes; defaults are reloaded from the strap after reset.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            target      <= `OVSR_RESET_ZERO;
            trim        <= `OVSR_RESET_ZERO;
            cal_offset  <= `OVSR_RESET_ZERO;
            ceiling     <= `OVSR_RESET_ZERO;
            margin_hi   <= `OVSR_RESET_ZERO;
            strap_limit <= `OVSR_RESET_ZERO;
        end else if (load_defaults) begin
            target      <= strap_code;
            ceiling     <= ceil_calc[W-1:0];
            margin_hi   <= mhi_calc[W-1:0];
            strap_limit <= ceil_calc[W-1:0];
        end else if (wr_en) begin
            case (wr_addr)
                `OVSR_ADDR_TARGET:     target <= wr_data;
                `OVSR_ADDR_TRIM:       trim <= ovsr_trim_lim(wr_data);
                `OVSR_ADDR_CAL_OFFSET: cal_offset <= wr_data;
                // The ceiling moves only on its own write or the default load, never with a target write.
                `OVSR_ADDR_CEILING: begin
                    ceiling <= (wr_data > `OVSR_CEIL_ABS_MAX) ? `OVSR_CEIL_ABS_MAX : wr_data;
                end
                `OVSR_ADDR_MARGIN_HI:  margin_hi <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // Read multiplexer; unmapped offsets return zero with no hit.
    always @* begin
        rd_hit  = 1'b1;
        rd_data = `OVSR_RESET_ZERO;
        case (rd_addr)
            `OVSR_ADDR_TARGET:     rd_data = target;
            `OVSR_ADDR_TRIM:       rd_data = trim;
            `OVSR_ADDR_CAL_OFFSET: rd_data = cal_offset;
            `OVSR_ADDR_CEILING:    rd_data = ceiling;
            `OVSR_ADDR_MARGIN_HI:  rd_data = margin_hi;
            default:               rd_hit  = 1'b0;
        endcase
    end

    // Command path: select setpoint, add trim and offset, clamp to ceiling.
    always @* begin
        // Target capped at 115 percent of strap, or the ceiling if that is higher.
        if (ceiling > strap_limit)
            nominal = (target > ceiling) ? ceiling : target;
        else
            nominal = (target > strap_limit) ? strap_limit : target;
        if (operation[7:6] == `OVSR_OP_ON && operation[5:4] == `OVSR_MARGIN_HIGH)
            base = margin_hi;
        else
            base = nominal;
        sum = {3'b000, base} + {{3{trim[W-1]}}, trim} + {{3{cal_offset[W-1]}}, cal_offset};
        if (sum[W+2])
            next_vout = `OVSR_RESET_ZERO;
        else if (sum[W+1:W] != 2'b00 || sum[W-1:0] > ceiling)
            next_vout = ceiling;
        else
            next_vout = sum[W-1:0];
    end

    // The commanded output is registered.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            vout_cmd <= `OVSR_RESET_ZERO;
        else
            vout_cmd <= next_vout;
    end
endmodule // ovsr_phase

// File: logic/ovsr_bank.v
// Top of the paged output voltage setpoint register bank.
`include "ovsr_regs.vh"
module ovsr_bank #(
    parameter W = 16
) (
    input  wire         REF_CLK,
    input  wire         ARST_N,
    input  wire [W-1:0] SETPOINT_STRAP_PIN,
    input  wire [7:0]   PAGE,
    input  wire [7:0]   OPERATION_PH1,
    input  wire [7:0]   OPERATION_PH2,
    input  wire         WR_EN,
    input  wire [7:0]   ADDR,
    input  wire [W-1:0] WR_DATA,
    output reg  [W-1:0] RD_DATA,
    output reg          RD_VALID,
    output wire [W-1:0] VOUT_CMD_PH1,
    output wire [W-1:0] VOUT_CMD_PH2
);
    reg  [W-1:0] strap_s1;   // First synchroniser stage for the strap pins.
    reg  [W-1:0] strap_s2;   // Second stage, the only one logic reads.
    reg  [1:0]   load_cnt;   // Counts cycles after reset until strap is settled.
    wire         load_pulse; // One-cycle default load.
    wire         wr_ph1;     // Write steered to phase one.
    wire         wr_ph2;     // Write steered to phase two.
    wire [W-1:0] rd_ph1;     // Phase one read data.
    wire [W-1:0] rd_ph2;     // Phase two read data.
    wire         hit_ph1;    // Phase one address hit.
    wire         hit_ph2;    // Phase two address hit.

    // The strap pins are asynchronous, so they pass two flip-flops first.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strap_s1 <= `OVSR_RESET_ZERO;
            strap_s2 <= `OVSR_RESET_ZERO;
        end else begin
            strap_s1 <= SETPOINT_STRAP_PIN;
            strap_s2 <= strap_s1;
        end
    end

    // Wait until the synchroniser holds the real strap, then load defaults once.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N)
            load_cnt <= `OVSR_LOAD_IDLE;
        else if (load_cnt != `OVSR_LOAD_DONE)
            load_cnt <= load_cnt + `OVSR_LOAD_STEP;
    end
    assign load_pulse = (load_cnt == `OVSR_LOAD_AT);

    // Page decode: a write to both pages lands in both register sets.
    assign wr_ph1 = WR_EN && (PAGE == `OVSR_PAGE_PH1 || PAGE == `OVSR_PAGE_BOTH);
    assign wr_ph2 = WR_EN && (PAGE == `OVSR_PAGE_PH2 || PAGE == `OVSR_PAGE_BOTH);

    // Two independent page instances keep separate register sets.
    ovsr_phase #(.W(W)) u_ph1 (
        .clk           (REF_CLK),
        .arst_n        (ARST_N),
        .load_defaults (load_pulse),
        .strap_code    (strap_s2),
        .wr_en         (wr_ph1),
        .wr_addr       (ADDR),
        .wr_data       (WR_DATA),
        .rd_addr       (ADDR),
        .operation     (OPERATION_PH1),
        .rd_data       (rd_ph1),
        .rd_hit        (hit_ph1),
        .vout_cmd      (VOUT_CMD_PH1)
    );
    ovsr_phase #(.W(W)) u_ph2 (
        .clk           (REF_CLK),
        .arst_n        (ARST_N),
        .load_defaults (load_pulse),
        .strap_code    (strap_s2),
        .wr_en         (wr_ph2),
        .wr_addr       (ADDR),
        .wr_data       (WR_DATA),
        .rd_addr       (ADDR),
        .operation     (OPERATION_PH2),
        .rd_data       (rd_ph2),
        .rd_hit        (hit_ph2),
        .vout_cmd      (VOUT_CMD_PH2)
    );

    // Registered read data; page both reads phase one, a simple tie-break.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RD_DATA  <= `OVSR_RESET_ZERO;
            RD_VALID <= 1'b0;
        end else if (PAGE == `OVSR_PAGE_PH2) begin
            RD_DATA  <= rd_ph2;
            RD_VALID <= hit_ph2;
        end else begin
            RD_DATA  <= rd_ph1;
            RD_VALID <= hit_ph1 && (PAGE == `OVSR_PAGE_PH1 || PAGE == `OVSR_PAGE_BOTH);
        end
    end
endmodule // ovsr_bank

// File: verif/ovsr_host.sv
// Host model issuing paged writes and reads.
module ovsr_host (
    input  wire logic  clk,
    output logic       wr_en,
    output logic [7:0] page,
    output logic [7:0] addr,
    output logic [15:0] wr_data,
    output logic       rd_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {wr_en, rd_req, page, addr, wr_data} = '0;
    // Page goes out with the access and holds to the taking edge.
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {page, addr, wr_data, wr_en} <= {p, a, d, 1'b1};
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d; // Released data no longer shows the written word.
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] a);
        @(posedge clk);
        {page, addr, rd_req} <= {p, a, 1'b1};
        @(posedge clk);
        rd_req <= 1'b0;
    endtask
endmodule // ovsr_host

// File: verif/ovsr_bank_chk.sv
// Port assertions for the paged setpoint bank.
module ovsr_bank_chk #(parameter W = 16) (
    input wire         REF_CLK,
    input wire         ARST_N,
    input wire [W-1:0] SETPOINT_STRAP_PIN,
    input wire [7:0]   PAGE,
    input wire [7:0]   OPERATION_PH1,
    input wire         WR_EN,
    input wire [7:0]   ADDR,
    input wire [W-1:0] WR_DATA,
    input wire [W-1:0] RD_DATA,
    input wire         RD_VALID,
    input wire [W-1:0] VOUT_CMD_PH1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] up; // Edges since reset; defaults settle before it saturates.
    always_ff @(posedge REF_CLK or negedge ARST_N)
        if (!ARST_N) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    wire ok_pg = PAGE == 8'h00 || PAGE == 8'h01 || PAGE == 8'hff;
    wire mapped = ADDR >= 8'h21 && ADDR <= 8'h25;
    sequence s_wr(a, c); WR_EN && ADDR == a && ok_pg && c; endsequence
    sequence s_hold; !WR_EN && $stable(ADDR) && $stable(PAGE); endsequence
    a_rd_hit: assert property (ok_pg && mapped |=> RD_VALID) else $error("hit lost");
    a_rd_unmapped: assert property (!mapped |=> !RD_VALID && RD_DATA == 16'h0000)
        else $error("unmapped read");
    a_rd_bad_page: assert property (!ok_pg |=> !RD_VALID) else $error("bad page hit");
    a_target_readback: assert property (s_wr(8'h21, 1) ##1 s_hold |=> RD_DATA == $past(WR_DATA, 2))
        else $error("target readback");
    a_ceil_limit: assert property (s_wr(8'h24, WR_DATA > 16'hb000) ##1 s_hold |=> RD_DATA == 16'hb000)
        else $error("ceiling limit");
    a_trim_pos_max: assert property (s_wr(8'h22, !WR_DATA[15] && WR_DATA > 16'h04cd) ##1 s_hold
        |=> RD_DATA == 16'h04cd) else $error("trim high");
    a_trim_neg_max: assert property (s_wr(8'h22, WR_DATA[15] && WR_DATA < 16'hfb33) ##1 s_hold
        |=> RD_DATA == 16'hfb33) else $error("trim low");
    a_vout_steady: assert property ((up == 3'h7 && !WR_EN && $stable(OPERATION_PH1)) [*3]
        |=> $stable(VOUT_CMD_PH1)) else $error("vout moved");
    a_vout_abs_max: assert property (VOUT_CMD_PH1 <= 16'hb000) else $error("vout above limit");
endmodule // ovsr_bank_chk
bind ovsr_bank ovsr_bank_chk #(.W(W)) u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PAGE(PAGE),
    .SETPOINT_STRAP_PIN(SETPOINT_STRAP_PIN), .OPERATION_PH1(OPERATION_PH1), .WR_EN(WR_EN), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .VOUT_CMD_PH1(VOUT_CMD_PH1));

// File: verif/ovsr_bank_test.sv
// Self-checking bench for the paged setpoint bank.
module ovsr_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] strap = 16'h2000; // Strap of 1.0 V.
    logic [7:0]  op1 = 8'h80;      // Both phases on, nominal.
    logic [7:0]  op2 = 8'h80;
    wire         wr_en, rd_req, rd_valid;
    wire  [7:0]  page, addr;
    wire  [15:0] wr_data, rd_data, vout1, vout2;
    logic [16:0] notes[$];         // Expected {valid, data} per read.
    logic        pend = 1'b0;
    int          error_cnt = 0;
    int          checks_done = 0;
    logic [15:0] r;
    logic [15:0] dflt[5] = '{16'h2000, 16'h0000, 16'h0000, 16'h24cc, 16'h2199};
    always #20 ref_clk = ~ref_clk;
    ovsr_host HOST (.clk(ref_clk), .wr_en(wr_en), .page(page), .addr(addr), .wr_data(wr_data), .rd_req(rd_req));
    ovsr_bank DUT (.REF_CLK(ref_clk), .ARST_N(arst_n), .SETPOINT_STRAP_PIN(strap), .PAGE(page),
        .OPERATION_PH1(op1), .OPERATION_PH2(op2), .WR_EN(wr_en), .ADDR(addr), .WR_DATA(wr_data),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .VOUT_CMD_PH1(vout1), .VOUT_CMD_PH2(vout2));
    task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read data lands on the edge that samples the request and is compared one edge later.
    always @(posedge ref_clk) begin
        pend <= rd_req;
        if (pend) cmp("read", notes.pop_front(), {rd_valid, rd_data});
    end
    task automatic rdc(input logic [7:0] p, input logic [7:0] a, input logic [16:0] exp);
        notes.push_back(exp);
        HOST.rd(p, a);
    endtask
    task automatic vchk(input logic [15:0] e1, input logic [15:0] e2);
        repeat (3) @(posedge ref_clk);
        cmp("vout_ph1", {1'b0, e1}, {1'b0, vout1});
        cmp("vout_ph2", {1'b0, e2}, {1'b0, vout2});
    endtask
    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(43128));
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        foreach (dflt[i]) begin
            rdc(8'h01, 8'(i) + 8'h21, {1'b1, dflt[i]});
            rdc(8'h00, 8'(i) + 8'h21, {1'b1, dflt[i]});
        end
        rdc(8'h01, 8'h26, 17'h00000);
        HOST.wr(8'h02, 8'h21, 16'h1234);
        rdc(8'hff, 8'h21, 17'h12000);
        vchk(16'h2000, 16'h2000);
        HOST.wr(8'h00, 8'h21, 16'h2800);
        vchk(16'h2000, 16'h24cc);
        rdc(8'h00, 8'h21, 17'h12800);
        rdc(8'h00, 8'h24, 17'h124cc);
        HOST.wr(8'h00, 8'h24, 16'h3000);
        vchk(16'h2000, 16'h2800);
        HOST.wr(8'h00, 8'h24, 16'hffff);
        rdc(8'h00, 8'h24, 17'h1b000);
        HOST.wr(8'h01, 8'h22, 16'h0100);
        vchk(16'h2100, 16'h2800);
        HOST.wr(8'h01, 8'h22, 16'h7fff);
        rdc(8'h01, 8'h22, 17'h104cd);
        HOST.wr(8'h01, 8'h22, 16'h8000);
        rdc(8'h01, 8'h22, 17'h1fb33);
        HOST.wr(8'h01, 8'h23, 16'h0200);
        vchk(16'h1d33, 16'h2800);
        op1 <= 8'ha0;
        vchk(16'h1ecc, 16'h2800);
        HOST.wr(8'hff, 8'h25, 16'h3000);
        op2 <= 8'ha0;
        vchk(16'h24cc, 16'h3000);
        repeat (4) begin
            r = 16'($urandom);
            HOST.wr(8'h00, 8'h23, r);
            rdc(8'h00, 8'h23, {1'b1, r});
        end
        repeat (3) @(posedge ref_clk);
        // A second reset in mid-run must clear the outputs and reload the strap defaults.
        arst_n <= 1'b0;
        @(posedge ref_clk);
        cmp("reset_vout_ph1", 17'h00000, {1'b0, vout1});
        cmp("reset_vout_ph2", 17'h00000, {1'b0, vout2});
        cmp("reset_read", 17'h00000, {rd_valid, rd_data});
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // Both phases are still in margin high, so the reloaded margin default drives them.
        vchk(16'h2199, 16'h2199);
        rdc(8'h01, 8'h22, 17'h10000);
        rdc(8'h00, 8'h23, 17'h10000);
        rdc(8'h00, 8'h21, 17'h12000);
        rdc(8'h00, 8'h24, 17'h124cc);
        repeat (3) @(posedge ref_clk);
        summarize();
    end
    // The run needs some 130 cycles; a hang is cut off far beyond that.
    initial begin
        #(40 * 2000);
        error_cnt++;
        summarize();
    end
endmodule // ovsr_bank_test
